// File: logic/obd_cfg_core.sv
// Command interpreter for header, protocol, receive filter and timer settings.
// Assumes a protocol engine on the same clock pulsing its status inputs one cycle.
`timescale 1ns/1ps
module obd_cfg_core
  import obd_cfg_pkg::*;
#(
  parameter int TMO_STEP_CYCLES  = TMO_STEP_CYC,
  parameter int WAKE_STEP_CYCLES = WAKE_STEP_CYC,
  parameter int NV_WRITE_CYCLES  = NV_WRITE_CYC
) (
  input  wire logic                    clk_i,
  input  wire logic                    rst_b_i,
  input  wire logic [ADDR_W-1:0]       addr_i,
  input  wire logic [DATA_W-1:0]       wdata_i,
  input  wire logic                    wr_i,
  input  wire logic                    rd_i,
  output logic      [DATA_W-1:0]       rdata_o,
  input  wire logic                    start_req_i,
  input  wire logic                    init_ok_i,
  input  wire logic                    init_fail_i,
  input  wire logic                    link_lost_i,
  input  wire logic                    req_sent_i,
  input  wire logic                    resp_rcvd_i,
  input  wire logic                    host_idle_i,
  input  wire logic                    adaptive_en_i,
  input  wire logic [7:0]              adaptive_tmo_i,
  output logic                         try_start_o,
  output logic      [3:0]              try_proto_o,
  output obd_cfg_pkg::header_type      tx_header_o,
  output logic      [28:0]             can_id_o,
  output logic                         can_id_29_o,
  output logic                         kwp_len_in_fmt_o,
  output logic                         kwp_len_byte_o,
  output logic                         rx_filter_en_o,
  output logic      [7:0]              rx_addr_o,
  output logic                         bus_init_err_o,
  output logic                         no_data_o,
  output logic                         resp_end_o,
  output logic                         wakeup_o,
  output logic                         resp_discard_o,
  output logic                         nv_write_o,
  output logic      [3:0]              nv_proto_o
);
  import obd_cfg_pkg::*;

  function automatic logic is_hex(input logic [7:0] c);
    return (c >= 8'h30 && c <= 8'h39) || (c >= 8'h41 && c <= 8'h46);
  endfunction

  function automatic logic [3:0] hex_val(input logic [7:0] c);
    return (c <= 8'h39) ? c[3:0] : c[3:0] + 4'h9;
  endfunction

  function automatic logic [7:0] upper(input logic [7:0] c);
    return (c >= 8'h61 && c <= 8'h7a) ? c - 8'h20 : c;
  endfunction

  logic [7:0]     buf_reg [BUF_DEPTH];
  logic [3:0]     cnt_reg;
  logic           ovf_reg;
  logic [7:0]     ch;
  logic           char_wr, exec;
  header_type     hdr_reg;
  logic [4:0]     cp_reg;
  logic [3:0]     sel_reg, nv_reg, cur_reg;
  logic           auto_reg, mem_reg;
  logic           filt_reg;
  logic [7:0]     rxa_reg, tmo_reg, tmo_def_reg, wake_reg, wake_keep_reg;
  logic           ok_reg, err_reg, berr_reg;
  link_state_type state_reg;
  logic           dflt_hdr_reg;
  logic [3:0]     tries_reg;
  logic [CNT_W-1:0] nv_cnt_reg;
  cmd_type        cmd;
  logic [23:0]    arg_hdr;
  logic [7:0]     arg_byte;
  logic [3:0]     sp_proto;
  logic           sp_auto, sp_write;
  logic           hx [BUF_DEPTH];
  logic           nv_req, search_auto;
  logic [3:0]     next_proto;

  assign ch      = upper(wdata_i[7:0]);
  assign char_wr = wr_i && addr_i == OFS_CMD_CHAR;
  assign exec    = char_wr && ch == CHAR_CR;

  // Line buffer; spaces dropped and letters folded before storage
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_reg <= 4'h0;
      ovf_reg <= 1'b0;
      for (int i = 0; i < BUF_DEPTH; i++) begin
        buf_reg[i] <= 8'h00;
      end
    end else if (exec) begin
      cnt_reg <= 4'h0;
      ovf_reg <= 1'b0;
    end else if (char_wr && ch != CHAR_SPACE) begin
      if (cnt_reg == 4'(BUF_DEPTH)) begin
        ovf_reg <= 1'b1;
      end else begin
        buf_reg[cnt_reg[2:0]] <= ch;
        cnt_reg <= cnt_reg + 4'h1;
      end
    end
  end

  // Decode of a complete line; anything malformed maps to CMD_BAD
  always_comb begin
    cmd      = CMD_BAD;
    arg_hdr  = 24'h000000;
    arg_byte = {hex_val(buf_reg[2]), hex_val(buf_reg[3])};
    sp_proto = PROTO_AUTO;
    sp_auto  = 1'b0;
    sp_write = 1'b0;
    for (int i = 0; i < BUF_DEPTH; i++) begin
      hx[i] = is_hex(buf_reg[i]);
    end
    if (ovf_reg) begin
      cmd = CMD_BAD;
    end else if (cnt_reg == 4'h0) begin
      cmd = CMD_NONE;
    end else begin
      case ({buf_reg[0], buf_reg[1]})
        "SH": begin
          if (cnt_reg == 4'h5 && hx[2] && hx[3] && hx[4]) begin
            cmd     = CMD_SH3;
            arg_hdr = {13'h0000, 3'(hex_val(buf_reg[2])), hex_val(buf_reg[3]),
                       hex_val(buf_reg[4])};
          end else if (cnt_reg == 4'h8 && hx[2] && hx[3] && hx[4] && hx[5] && hx[6] && hx[7]) begin
            cmd     = CMD_SH6;
            arg_hdr = {arg_byte, hex_val(buf_reg[4]), hex_val(buf_reg[5]),
                       hex_val(buf_reg[6]), hex_val(buf_reg[7])};
          end
        end
        "SP": begin
          if (cnt_reg == 4'h3 && hx[2]) begin
            sp_proto = hex_val(buf_reg[2]);
            sp_auto  = sp_proto == PROTO_AUTO;
            sp_write = sp_proto != PROTO_AUTO;
            cmd      = (sp_proto <= PROTO_LAST) ? CMD_SP : CMD_BAD;
          end else if (cnt_reg == 4'h4) begin
            if (buf_reg[2] == CHAR_0 && buf_reg[3] == CHAR_0) begin
              sp_auto  = 1'b1;
              sp_write = 1'b1;
              cmd      = CMD_SP;
            end else if ((buf_reg[2] == CHAR_A && hx[3]) || (buf_reg[3] == CHAR_A && hx[2])) begin
              sp_proto = (buf_reg[2] == CHAR_A) ? hex_val(buf_reg[3]) : hex_val(buf_reg[2]);
              sp_auto  = 1'b1;
              sp_write = sp_proto != PROTO_AUTO;
              cmd      = (sp_proto <= PROTO_LAST) ? CMD_SP : CMD_BAD;
            end
          end
        end
        "SR", "RA": cmd = (cnt_reg == 4'h4 && hx[2] && hx[3]) ? CMD_SR : CMD_BAD;
        "ST": cmd = (cnt_reg == 4'h4 && hx[2] && hx[3]) ? CMD_ST : CMD_BAD;
        "SW": cmd = (cnt_reg == 4'h4 && hx[2] && hx[3]) ? CMD_SW : CMD_BAD;
        "CP": cmd = (cnt_reg == 4'h4 && hx[2] && hx[3]) ? CMD_CP : CMD_BAD;
        "AR": cmd = (cnt_reg == 4'h2) ? CMD_AR : CMD_BAD;
        "WS": cmd = (cnt_reg == 4'h2) ? CMD_DEF : CMD_BAD;
        "M0": cmd = (cnt_reg == 4'h2) ? CMD_MEM0 : CMD_BAD;
        "M1": cmd = (cnt_reg == 4'h2) ? CMD_MEM1 : CMD_BAD;
        default: begin
          if (cnt_reg == 4'h1 && (buf_reg[0] == "D" || buf_reg[0] == "Z")) begin
            cmd = CMD_DEF;
          end
        end
      endcase
    end
  end

  // Result flags of the last executed line
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ok_reg  <= 1'b0;
      err_reg <= 1'b0;
    end else if (exec && cmd != CMD_NONE) begin
      ok_reg  <= cmd != CMD_BAD;
      err_reg <= cmd == CMD_BAD;
    end
  end

  // Header bytes and CAN priority bits
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      hdr_reg <= HDR_DEFAULT;
      cp_reg  <= CP_DEFAULT;
    end else if (exec) begin
      case (cmd)
        CMD_SH3, CMD_SH6: hdr_reg <= arg_hdr;
        CMD_CP:  cp_reg <= arg_byte[4:0];
        CMD_DEF: begin
          hdr_reg <= HDR_DEFAULT;
          cp_reg  <= CP_DEFAULT;
        end
        default: ;
      endcase
    end
  end

  // Receive address filter; the alias decodes to the same command
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      filt_reg <= 1'b0;
      rxa_reg  <= 8'h00;
    end else if (exec && cmd == CMD_SR) begin
      filt_reg <= 1'b1;
      rxa_reg  <= arg_byte;
    end else if (exec && (cmd == CMD_AR || cmd == CMD_DEF)) begin
      filt_reg <= 1'b0;
    end
  end

  // Timeout and wakeup settings; default of timeout is software programmable
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tmo_def_reg   <= TMO_DEFAULT;
      tmo_reg       <= TMO_DEFAULT;
      wake_reg      <= WAKE_DEFAULT;
      wake_keep_reg <= WAKE_DEFAULT;
    end else begin
      if (wr_i && addr_i == OFS_TMO_DEF) begin
        tmo_def_reg <= wdata_i[7:0];
      end
      if (exec && cmd == CMD_ST) begin
        tmo_reg <= (arg_byte == 8'h00) ? tmo_def_reg : arg_byte;
      end else if (exec && cmd == CMD_DEF) begin
        tmo_reg <= tmo_def_reg;
      end
      if (exec && cmd == CMD_SW) begin
        wake_reg <= arg_byte;
        if (arg_byte != 8'h00) begin
          wake_keep_reg <= arg_byte;
        end
      end else if (exec && cmd == CMD_DEF) begin
        wake_reg      <= WAKE_DEFAULT;
        wake_keep_reg <= WAKE_DEFAULT;
      end else if (state_reg == LINK_WAIT && init_ok_i) begin
        wake_reg <= wake_keep_reg;
      end
    end
  end

  // Protocol selection, memory option and nonvolatile default
  assign nv_req = (exec && cmd == CMD_SP && sp_write) ||
                  (state_reg == LINK_WAIT && init_ok_i && search_auto && mem_reg);
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sel_reg    <= PROTO_AUTO;
      auto_reg   <= 1'b1;
      mem_reg    <= MEM_DEFAULT;
      nv_reg     <= PROTO_AUTO;
      nv_write_o <= 1'b0;
      nv_cnt_reg <= '0;
    end else begin
      nv_write_o <= nv_req && nv_cnt_reg == '0;
      if (nv_req && nv_cnt_reg == '0) begin
        nv_reg     <= (exec && cmd == CMD_SP) ? sp_proto : cur_reg;
        nv_cnt_reg <= CNT_W'(NV_WRITE_CYCLES);
      end else if (nv_cnt_reg != '0) begin
        nv_cnt_reg <= nv_cnt_reg - 1'b1;
      end
      if (exec && cmd == CMD_SP) begin
        sel_reg  <= sp_proto;
        auto_reg <= sp_auto;
      end
      if (exec && cmd == CMD_MEM0) begin
        mem_reg <= 1'b0;
      end else if (exec && cmd == CMD_MEM1) begin
        mem_reg <= 1'b1;
      end
    end
  end
  assign nv_proto_o = nv_reg;

  // Search state machine
  assign search_auto = auto_reg || sel_reg == PROTO_AUTO;
  assign next_proto  = (cur_reg >= PROTO_LAST) ? PROTO_FIRST : cur_reg + 4'h1;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_reg      <= LINK_IDLE;
      cur_reg        <= PROTO_FIRST;
      tries_reg      <= 4'h0;
      dflt_hdr_reg   <= 1'b0;
      try_start_o    <= 1'b0;
      bus_init_err_o <= 1'b0;
      berr_reg       <= 1'b0;
    end else begin
      try_start_o    <= 1'b0;
      bus_init_err_o <= 1'b0;
      if (exec && cmd == CMD_SP) begin
        state_reg <= LINK_IDLE;
      end else begin
        case (state_reg)
          LINK_IDLE: begin
            if (start_req_i) begin
              cur_reg      <= (sel_reg == PROTO_AUTO) ? PROTO_FIRST : sel_reg;
              dflt_hdr_reg <= sel_reg == PROTO_AUTO;
              tries_reg    <= 4'h1;
              berr_reg     <= 1'b0;
              state_reg    <= LINK_TRY;
            end
          end
          LINK_TRY: begin
            try_start_o <= 1'b1;
            state_reg   <= LINK_WAIT;
          end
          LINK_WAIT: begin
            if (init_ok_i) begin
              dflt_hdr_reg <= 1'b0;
              state_reg    <= LINK_CONN;
            end else if (init_fail_i) begin
              if (search_auto && tries_reg < 4'(PROTO_COUNT)) begin
                cur_reg      <= next_proto;
                tries_reg    <= tries_reg + 4'h1;
                dflt_hdr_reg <= 1'b1;
                state_reg    <= LINK_TRY;
              end else begin
                bus_init_err_o <= 1'b1;
                berr_reg       <= 1'b1;
                dflt_hdr_reg   <= 1'b0;
                state_reg      <= LINK_IDLE;
              end
            end
          end
          LINK_CONN: begin
            if (link_lost_i) begin
              state_reg <= LINK_IDLE;
            end
          end
          default: state_reg <= LINK_IDLE;
        endcase
      end
    end
  end
  assign try_proto_o = cur_reg;

  // Frame format outputs follow the protocol in use
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tx_header_o      <= HDR_DEFAULT;
      can_id_o         <= 29'h00000000;
      can_id_29_o      <= 1'b0;
      kwp_len_in_fmt_o <= 1'b0;
      kwp_len_byte_o   <= 1'b0;
      rx_filter_en_o   <= 1'b0;
      rx_addr_o        <= 8'h00;
    end else begin
      tx_header_o <= dflt_hdr_reg ? HDR_DEFAULT : hdr_reg;
      can_id_29_o <= !(cur_reg == PROTO_CAN6 || cur_reg == PROTO_CAN8 || cur_reg >= PROTO_USR1);
      if (cur_reg == PROTO_CAN6 || cur_reg == PROTO_CAN8 || cur_reg >= PROTO_USR1) begin
        can_id_o <= {18'h00000, hdr_reg[10:0]};
      end else begin
        can_id_o <= {cp_reg, hdr_reg};
      end
      kwp_len_in_fmt_o <= (cur_reg == PROTO_KWPS || cur_reg == PROTO_KWPF) &&
                          hdr_reg.prio[3:0] != 4'h0;
      kwp_len_byte_o   <= (cur_reg == PROTO_KWPS || cur_reg == PROTO_KWPF) &&
                          hdr_reg.prio[3:0] == 4'h0;
      rx_filter_en_o   <= filt_reg && cur_reg != PROTO_J1939;
      rx_addr_o        <= rxa_reg;
    end
  end

  // Response timer; restarted by each request and each reply
  logic [CNT_W-1:0] tmo_pre_reg;
  logic [7:0]       tmo_steps_reg, tmo_lim;
  logic             tmo_run_reg, got_resp_reg;
  assign tmo_lim = (adaptive_en_i && adaptive_tmo_i < tmo_reg) ?
                   ((adaptive_tmo_i == 8'h00) ? 8'h01 : adaptive_tmo_i) : tmo_reg;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tmo_pre_reg   <= '0;
      tmo_steps_reg <= 8'h00;
      tmo_run_reg   <= 1'b0;
      got_resp_reg  <= 1'b0;
      no_data_o     <= 1'b0;
      resp_end_o    <= 1'b0;
    end else begin
      no_data_o  <= 1'b0;
      resp_end_o <= 1'b0;
      if (req_sent_i || resp_rcvd_i) begin
        tmo_run_reg   <= 1'b1;
        tmo_pre_reg   <= '0;
        tmo_steps_reg <= 8'h00;
        got_resp_reg  <= resp_rcvd_i;
      end else if (tmo_run_reg) begin
        if (tmo_pre_reg == CNT_W'(TMO_STEP_CYCLES - 1)) begin
          tmo_pre_reg <= '0;
          if (tmo_steps_reg + 8'h01 >= tmo_lim) begin
            tmo_run_reg <= 1'b0;
            no_data_o   <= !got_resp_reg && !resp_discard_o;
            resp_end_o  <= got_resp_reg && !resp_discard_o;
          end else begin
            tmo_steps_reg <= tmo_steps_reg + 8'h01;
          end
        end else begin
          tmo_pre_reg <= tmo_pre_reg + 1'b1;
        end
      end
    end
  end

  // Wakeup generator for the ISO and both KWP protocols (slow and fast init) while the host is quiet
  logic [CNT_W-1:0] wk_pre_reg;
  logic [7:0]       wk_steps_reg;
  logic             wk_active;
  assign wk_active = state_reg == LINK_CONN && host_idle_i && wake_reg != 8'h00 &&
                     (cur_reg == PROTO_ISO || cur_reg == PROTO_KWPS || cur_reg == PROTO_KWPF);
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wk_pre_reg     <= '0;
      wk_steps_reg   <= 8'h00;
      wakeup_o       <= 1'b0;
      resp_discard_o <= 1'b0;
    end else begin
      wakeup_o <= 1'b0;
      if (!wk_active) begin
        wk_pre_reg   <= '0;
        wk_steps_reg <= 8'h00;
      end else if (wk_pre_reg == CNT_W'(WAKE_STEP_CYCLES - 1)) begin
        wk_pre_reg <= '0;
        if (wk_steps_reg + 8'h01 >= wake_reg) begin
          wk_steps_reg <= 8'h00;
          wakeup_o     <= 1'b1;
        end else begin
          wk_steps_reg <= wk_steps_reg + 8'h01;
        end
      end else begin
        wk_pre_reg <= wk_pre_reg + 1'b1;
      end
      // Set wins over the timer end so a wakeup on that edge is still hidden
      if (wk_active && wakeup_o) begin
        resp_discard_o <= 1'b1;
      end else if (!host_idle_i || (tmo_run_reg == 1'b0 && !req_sent_i && !resp_rcvd_i)) begin
        resp_discard_o <= 1'b0;
      end
    end
  end

  // Register read port, data valid in the cycle after the strobe
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_o <= '0;
    end else if (rd_i) begin
      case (addr_i)
        OFS_STATUS: rdata_o <= {24'h000000, 1'b0, mem_reg, filt_reg, berr_reg,
                                state_reg == LINK_CONN, nv_cnt_reg != '0, err_reg, ok_reg};
        OFS_HEADER: rdata_o <= {8'h00, hdr_reg};
        OFS_PROTO:  rdata_o <= {11'h000, cp_reg, cur_reg, 3'h0, auto_reg, sel_reg, nv_reg};
        OFS_TIMING: rdata_o <= {8'h00, wake_keep_reg, wake_reg, tmo_reg};
        OFS_TMO_DEF: rdata_o <= {24'h000000, tmo_def_reg};
        default:    rdata_o <= '0;
      endcase
    end else begin
      rdata_o <= '0;
    end
  end
endmodule

// File: logic/obd_cfg_pkg.sv
// Constants, types and register map of the diagnostic link configuration block.
// Assumes a 100 MHz core clock; all timing counts derive from it here.
package obd_cfg_pkg;
  localparam int CLK_KHZ       = 100000;
  localparam int TMO_STEP_MS   = 4;
  localparam int WAKE_STEP_MS  = 20;
  localparam int NV_WRITE_MS   = 30;
  localparam int TMO_STEP_CYC  = TMO_STEP_MS * CLK_KHZ;
  localparam int WAKE_STEP_CYC = WAKE_STEP_MS * CLK_KHZ;
  localparam int NV_WRITE_CYC  = NV_WRITE_MS * CLK_KHZ;
  localparam int CNT_W         = 22;
  localparam int ADDR_W        = 8;
  localparam int DATA_W        = 32;
  localparam int BUF_DEPTH     = 8;
  localparam int PROTO_COUNT   = 12;

  // Register byte offsets
  localparam logic [7:0] OFS_CMD_CHAR = 8'h00;
  localparam logic [7:0] OFS_STATUS   = 8'h04;
  localparam logic [7:0] OFS_HEADER   = 8'h08;
  localparam logic [7:0] OFS_PROTO    = 8'h0c;
  localparam logic [7:0] OFS_TIMING   = 8'h10;
  localparam logic [7:0] OFS_TMO_DEF  = 8'h14;

  // Status field positions
  localparam int ST_OK_BIT    = 0;
  localparam int ST_ERR_BIT   = 1;
  localparam int ST_BUSY_BIT  = 2;
  localparam int ST_CONN_BIT  = 3;
  localparam int ST_BERR_BIT  = 4;
  localparam int ST_FILT_BIT  = 5;
  localparam int ST_MEM_BIT   = 6;

  // Protocol codes
  localparam logic [3:0] PROTO_AUTO  = 4'h0;
  localparam logic [3:0] PROTO_FIRST = 4'h1;
  localparam logic [3:0] PROTO_ISO   = 4'h3;
  localparam logic [3:0] PROTO_KWPS  = 4'h4;
  localparam logic [3:0] PROTO_KWPF  = 4'h5;
  localparam logic [3:0] PROTO_CAN6  = 4'h6;
  localparam logic [3:0] PROTO_CAN8  = 4'h8;
  localparam logic [3:0] PROTO_J1939 = 4'ha;
  localparam logic [3:0] PROTO_USR1  = 4'hb;
  localparam logic [3:0] PROTO_LAST  = 4'hc;

  // Reset values
  localparam logic [23:0] HDR_DEFAULT  = 24'h000000;
  localparam logic [4:0]  CP_DEFAULT   = 5'h00;
  localparam logic [7:0]  TMO_DEFAULT  = 8'h20;
  localparam logic [7:0]  WAKE_DEFAULT = 8'h96;
  localparam logic        MEM_DEFAULT  = 1'b0;

  // Characters
  localparam logic [7:0] CHAR_CR    = 8'h0d;
  localparam logic [7:0] CHAR_SPACE = 8'h20;
  localparam logic [7:0] CHAR_A     = 8'h41;
  localparam logic [7:0] CHAR_0     = 8'h30;

  typedef struct packed {
    logic [7:0] prio;
    logic [7:0] target;
    logic [7:0] source;
  } header_type;

  typedef enum {CMD_NONE, CMD_SH3, CMD_SH6, CMD_SP, CMD_SR, CMD_AR, CMD_ST, CMD_SW,
                CMD_CP, CMD_DEF, CMD_MEM0, CMD_MEM1, CMD_BAD} cmd_type;

  typedef enum {LINK_IDLE, LINK_TRY, LINK_WAIT, LINK_CONN} link_state_type;
endpackage

// File: dv/obd_cfg_core_assertions.sv
// Port checker for the configuration core.
// Assumes one clock, clk_i, and active-low async reset rst_b_i.
`timescale 1ns/1ps
module obd_cfg_checker (
  input wire logic        clk_i,
  input wire logic        rst_b_i,
  input wire logic        rd_i,
  input wire logic        host_idle_i,
  input wire logic [31:0] rdata_o,
  input wire logic        try_start_o,
  input wire logic        nv_write_o,
  input wire logic        bus_init_err_o,
  input wire logic        kwp_len_in_fmt_o,
  input wire logic        kwp_len_byte_o,
  input wire logic        no_data_o,
  input wire logic        resp_end_o,
  input wire logic        wakeup_o,
  input wire logic        resp_discard_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  // Read data only in the cycle after a read strobe
  rdata_quiet_a: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
    else $error("read data outside its slot");
  try_pulse_a: assert property (try_start_o |=> !try_start_o)
    else $error("try start longer than one cycle");
  nv_pulse_a: assert property (nv_write_o |=> !nv_write_o)
    else $error("nonvolatile write longer than one cycle");
  berr_pulse_a: assert property (bus_init_err_o |=> !bus_init_err_o)
    else $error("bus init error longer than one cycle");
  kwp_excl_a: assert property (!(kwp_len_in_fmt_o && kwp_len_byte_o))
    else $error("both length placements chosen");
  timer_excl_a: assert property (!(no_data_o && resp_end_o))
    else $error("no data and response end together");
  wake_idle_a: assert property (wakeup_o |-> $past(host_idle_i))
    else $error("wakeup while host busy");
  discard_rise_a: assert property (wakeup_o && host_idle_i |=> resp_discard_o)
    else $error("wakeup replies not discarded");
endmodule
bind obd_cfg_core obd_cfg_checker obd_cfg_checker_i (.clk_i, .rst_b_i, .rd_i, .host_idle_i,
  .rdata_o, .try_start_o, .nv_write_o, .bus_init_err_o, .kwp_len_in_fmt_o, .kwp_len_byte_o,
  .no_data_o, .resp_end_o, .wakeup_o, .resp_discard_o);

// File: dv/obd_engine_model.sv
// Protocol engine stand-in answering each try of the core.
// Assumes one shared clock; only protocol good_i initialises.
`timescale 1ns/1ps
module obd_engine_model (
  input  wire logic       clk_i,
  input  wire logic       try_start_i,
  input  wire logic [3:0] proto_i,
  input  wire logic [3:0] good_i,
  output logic            ok_o,
  output logic            fail_o
);
  logic [2:0] dly = 3'h0;
  // Slow answer, four cycles late, so the search state is held a while
  always_ff @(posedge clk_i) begin
    dly    <= {dly[1:0], try_start_i};
    ok_o   <= dly[2] && proto_i == good_i;
    fail_o <= dly[2] && proto_i != good_i;
  end
endmodule

// File: dv/testbench.sv
// Self-checking bench for the configuration core.
// Assumes short step parameters so timers finish in tens of cycles.
`timescale 1ns/1ps
module testbench;
  import obd_cfg_pkg::*;
  logic clk_i = 0, rst_b_i = 0, wr_i = 0, rd_i = 0, start_req_i = 0, link_lost_i = 0;
  logic req_sent_i = 0, resp_rcvd_i = 0, host_idle_i = 0, adaptive_en_i = 0;
  logic [7:0]  addr_i = 8'h00, adaptive_tmo_i = 8'h10;
  logic [31:0] wdata_i = 32'h0, rdata_o, got;
  logic [3:0]  good = 4'hf, try_proto_o;
  logic init_ok_i, init_fail_i, try_start_o, nv_write_o, bus_init_err_o;
  logic no_data_o, wakeup_o, kwp_len_in_fmt_o;
  header_type tx_header_o;
  logic [28:0] can_id_o;
  logic [7:0]  rx_addr_o;
  logic [3:0]  nv_proto_o;
  logic can_id_29_o, rx_filter_en_o;
  int num_errors = 0, checks_done = 0, nv = 0, berr = 0, wake = 0, nd = 0;
  `define W(n) repeat (n) @(posedge clk_i);
  `define CHK(n, e, v) begin checks_done++; if ((v) !== (e)) begin num_errors++; \
    $display("ERROR %s exp %0h got %0h", n, e, v); end end
  obd_cfg_core #(.TMO_STEP_CYCLES(4), .WAKE_STEP_CYCLES(4), .NV_WRITE_CYCLES(8)) obd_cfg_core_i (
    .clk_i, .rst_b_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .start_req_i, .init_ok_i,
    .init_fail_i, .link_lost_i, .req_sent_i, .resp_rcvd_i, .host_idle_i, .adaptive_en_i,
    .adaptive_tmo_i, .try_start_o, .try_proto_o, .tx_header_o, .can_id_o, .can_id_29_o,
    .kwp_len_in_fmt_o, .kwp_len_byte_o(), .rx_filter_en_o, .rx_addr_o, .bus_init_err_o,
    .no_data_o, .resp_end_o(), .wakeup_o, .resp_discard_o(), .nv_write_o, .nv_proto_o);
  obd_engine_model obd_engine_model_i (.clk_i, .try_start_i(try_start_o), .proto_i(try_proto_o),
    .good_i(good), .ok_o(init_ok_i), .fail_o(init_fail_i));
  // Clock and event counters
  initial forever #5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    nv += nv_write_o; berr += bus_init_err_o; wake += wakeup_o; nd += no_data_o;
  end
  // One strobe cycle; read data taken in the following cycle
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i); wr_i <= w; rd_i <= !w; addr_i <= a; wdata_i <= d;
    @(posedge clk_i); wr_i <= 0; rd_i <= 0;
    #1 got = rdata_o;
  endtask
  task automatic cmd(input string s);
    foreach (s[i]) bus(1, OFS_CMD_CHAR, {24'h0, s[i]});
    bus(1, OFS_CMD_CHAR, {24'h0, CHAR_CR});
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Watchdog well beyond the roughly 300 cycles the tests need
  initial begin #100000; num_errors++; tally_and_finish; end
  initial begin
    `W(6) rst_b_i <= 1;
    bus(0, OFS_TIMING, 0); `CHK("timing", 32'h00969620, got)
    cmd("s h 7df"); bus(0, OFS_HEADER, 0); `CHK("hdr3", 32'h0007df, got)
    cmd("SH12G"); bus(0, OFS_HEADER, 0); `CHK("hdrbad", 32'h0007df, got)
    bus(0, OFS_STATUS, 0); `CHK("err", 1'b1, got[ST_ERR_BIT])
    cmd("ST00"); bus(0, OFS_TIMING, 0); `CHK("tmo", 8'h20, got[7:0])
    cmd("SW00"); bus(0, OFS_TIMING, 0); `CHK("wake", 16'h9600, got[23:8])
    cmd("SR5A"); bus(0, OFS_STATUS, 0); `CHK("filt", 1'b1, got[ST_FILT_BIT])
    `CHK("rxa", 8'h5a, rx_addr_o)
    `CHK("rxen", 1'b1, rx_filter_en_o)
    cmd("AR"); bus(0, OFS_STATUS, 0); `CHK("nofilt", 1'b0, got[ST_FILT_BIT])
    cmd("SP0"); cmd("SP00"); `W(12) `CHK("nv00", 1, nv)
    // Fixed protocol that never initialises
    cmd("SP3"); `W(12) start_req_i <= 1; `W(1) start_req_i <= 0; `W(14)
    `CHK("berr", 1, berr)
    `CHK("nv3", 2, nv)
    // Auto marker after the digit, first try fails, next code found
    cmd("SH810011"); cmd("S P 4 A"); good <= 4'h5; `W(12)
    start_req_i <= 1; `W(1) start_req_i <= 0; `W(30)
    `CHK("proto", 4'h5, try_proto_o)
    `CHK("hdr", 24'h810011, tx_header_o)
    `CHK("kwp", 1'b1, kwp_len_in_fmt_o)
    `CHK("nv4a", 3, nv)
    `CHK("nvp", 4'h4, nv_proto_o)
    `CHK("canid", 29'h0810011, can_id_o)
    `CHK("id29", 1'b1, can_id_29_o)
    cmd("SW02"); host_idle_i <= 1; `W(20) host_idle_i <= 0;
    `CHK("wakeups", 1'b1, wake > 1)
    cmd("ST02"); adaptive_en_i <= 1; `W(4)
    req_sent_i <= 1; `W(1) req_sent_i <= 0; `W(12)
    `CHK("nodata", 1, nd)
    cmd("Z"); bus(0, OFS_HEADER, 0); `CHK("hdrdef", 32'h0, got)
    bus(0, OFS_TIMING, 0); `CHK("timdef", 32'h00969620, got)
    tally_and_finish;
  end
endmodule
